// *** logic/dbc_bank.sv ***
// one bank's state machine with its own timer and burst counter
module dbc_bank (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   input wire logic clk_en,
   // command aimed at this bank
   input wire logic hit,
   input wire dbc_pkg::dbc_cmd_t cmd,
   input wire logic auto_pre,
   input wire logic pre_all,
   // state and command legality
   output dbc_pkg::dbc_bank_state_t state,
   output logic legal
);
   dbc_pkg::dbc_bank_state_t state_q, state_d;
   logic [dbc_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [dbc_pkg::CNT_W-1:0] burst_q, burst_d;

   function automatic logic [dbc_pkg::CNT_W-1:0] to_cnt(input int n);
      return n[dbc_pkg::CNT_W-1:0];
   endfunction

   assign state = state_q;

   always_comb begin
      legal = 1'b0;
      case (state_q)
         dbc_pkg::DBC_BK_IDLE: legal = (cmd == dbc_pkg::DBC_CMD_ACT) ||
            (cmd == dbc_pkg::DBC_CMD_PRE);
         dbc_pkg::DBC_BK_ACTIVE: legal = (cmd == dbc_pkg::DBC_CMD_RD) ||
            (cmd == dbc_pkg::DBC_CMD_WR) || (cmd == dbc_pkg::DBC_CMD_PRE);
         // bl4 bursts cannot be cut, so new column commands wait for the burst end
         dbc_pkg::DBC_BK_READ: legal = (cmd == dbc_pkg::DBC_CMD_PRE) ||
            (burst_q == dbc_pkg::CNT_ZERO && cmd != dbc_pkg::DBC_CMD_ACT);
         dbc_pkg::DBC_BK_WRITE: legal = (cmd == dbc_pkg::DBC_CMD_PRE) ||
            (burst_q == dbc_pkg::CNT_ZERO && cmd != dbc_pkg::DBC_CMD_ACT);
         dbc_pkg::DBC_BK_PRECHARGING: legal = (cmd == dbc_pkg::DBC_CMD_PRE) && pre_all;
         default: legal = 1'b0;
      endcase
   end

   always_comb begin
      state_d = state_q;
      cnt_d = (cnt_q != dbc_pkg::CNT_ZERO) ? cnt_q - dbc_pkg::CNT_ONE : cnt_q;
      burst_d = (burst_q != dbc_pkg::CNT_ZERO) ? burst_q - dbc_pkg::CNT_ONE : burst_q;
      if (hit && legal) begin
         case (cmd)
            dbc_pkg::DBC_CMD_ACT: begin
               state_d = dbc_pkg::DBC_BK_ACTIVATING;
               cnt_d = to_cnt(dbc_pkg::T_RCD_CK - 1);
            end
            dbc_pkg::DBC_CMD_RD, dbc_pkg::DBC_CMD_WR: begin
               burst_d = to_cnt(dbc_pkg::BURST_CK);
               // a10 picks auto precharge; timer then covers burst plus trp
               cnt_d = to_cnt(dbc_pkg::BURST_CK + dbc_pkg::T_RP_CK - 1);
               if (cmd == dbc_pkg::DBC_CMD_RD) begin
                  state_d = auto_pre ? dbc_pkg::DBC_BK_RD_AP : dbc_pkg::DBC_BK_READ;
               end else begin
                  state_d = auto_pre ? dbc_pkg::DBC_BK_WR_AP : dbc_pkg::DBC_BK_WRITE;
               end
            end
            dbc_pkg::DBC_CMD_PRE: begin
               state_d = dbc_pkg::DBC_BK_PRECHARGING;
               cnt_d = to_cnt(dbc_pkg::T_RP_CK - 1);
            end
            default: state_d = state_q;
         endcase
      end else begin
         case (state_q)
            dbc_pkg::DBC_BK_ACTIVATING: if (cnt_q == dbc_pkg::CNT_ZERO) begin
               state_d = dbc_pkg::DBC_BK_ACTIVE;
            end
            dbc_pkg::DBC_BK_READ, dbc_pkg::DBC_BK_WRITE: if (burst_q == dbc_pkg::CNT_ZERO) begin
               state_d = dbc_pkg::DBC_BK_ACTIVE;
            end
            dbc_pkg::DBC_BK_RD_AP, dbc_pkg::DBC_BK_WR_AP, dbc_pkg::DBC_BK_PRECHARGING:
               if (cnt_q == dbc_pkg::CNT_ZERO && burst_q == dbc_pkg::CNT_ZERO) begin
                  state_d = dbc_pkg::DBC_BK_IDLE;
               end
            default: state_d = state_q;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= dbc_pkg::DBC_BK_IDLE;
         cnt_q <= dbc_pkg::CNT_ZERO;
         burst_q <= dbc_pkg::CNT_ZERO;
      end else if (clk_en) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         burst_q <= burst_d;
      end
   end
endmodule // dbc_bank

// *** logic/dbc_ctrl.sv ***
module dbc_ctrl (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   input wire logic clk_en,
   // command pins
   input wire logic cke,
   input wire dbc_pkg::dbc_cmd_bus_t cmd_in,
   // status
   output dbc_pkg::dbc_status_t status,
   output dbc_pkg::dbc_dev_state_t dev_state,
   output logic self_refresh
);
   ////////////////////////////////////////////////////////////////////////////
   dbc_pkg::dbc_dev_state_t dev_q, dev_d;
   dbc_pkg::dbc_status_t stat_q, stat_d;
   logic [dbc_pkg::CNT_W-1:0] dcnt_q, dcnt_d;
   logic cke_prev_q;
   logic sr_q, sr_d;
   logic sr_exit_seen_q;
   dbc_pkg::dbc_cmd_t cmd;
   dbc_pkg::dbc_bank_state_t bstate [dbc_pkg::NUM_BANKS];
   logic [dbc_pkg::NUM_BANKS-1:0] blegal, bhit, bidle;
   logic valid, all_idle, pre_all, cmd_ok;

   function automatic dbc_pkg::dbc_cmd_t decode(input dbc_pkg::dbc_cmd_bus_t c,
                                                input logic ck);
      decode = dbc_pkg::DBC_CMD_NONE;
      if (!c.cs_n) begin
         case ({c.ras_n, c.cas_n, c.we_n})
            3'h3: decode = dbc_pkg::DBC_CMD_ACT;
            3'h5: decode = dbc_pkg::DBC_CMD_RD;
            3'h4: decode = dbc_pkg::DBC_CMD_WR;
            3'h2: decode = dbc_pkg::DBC_CMD_PRE;
            3'h1: decode = ck ? dbc_pkg::DBC_CMD_REF : dbc_pkg::DBC_CMD_SRE;
            3'h0: decode = dbc_pkg::DBC_CMD_LMR;
            default: decode = dbc_pkg::DBC_CMD_NONE;
         endcase
      end
   endfunction

   function automatic logic [dbc_pkg::CNT_W-1:0] to_cnt(input int n);
      return n[dbc_pkg::CNT_W-1:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // command qualification
   assign cmd = decode(cmd_in, cke);
   // commands count only with cke high now and last cycle, in the normal device state
   assign valid = cke_prev_q && cke && (dev_q == dbc_pkg::DBC_DEV_NORMAL);
   assign pre_all = cmd_in.addr[dbc_pkg::AP_BIT];
   assign all_idle = &bidle;

   always_comb begin
      for (int i = 0; i < dbc_pkg::NUM_BANKS; i++) begin
         bidle[i] = (bstate[i] == dbc_pkg::DBC_BK_IDLE);
         // bank address selects the target; precharge-all hits every bank
         bhit[i] = valid && ((cmd_in.ba == i[dbc_pkg::BA_W-1:0]) ||
                   (cmd == dbc_pkg::DBC_CMD_PRE && pre_all));
      end
   end

   // other banks never veto, except refresh, mode load or precharge all
   always_comb begin
      cmd_ok = 1'b0;
      case (cmd)
         dbc_pkg::DBC_CMD_REF, dbc_pkg::DBC_CMD_LMR: cmd_ok = all_idle;
         dbc_pkg::DBC_CMD_PRE: cmd_ok = pre_all ? &blegal : blegal[cmd_in.ba];
         dbc_pkg::DBC_CMD_ACT, dbc_pkg::DBC_CMD_RD, dbc_pkg::DBC_CMD_WR:
            cmd_ok = blegal[cmd_in.ba];
         default: cmd_ok = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // bank machines
   for (genvar g = 0; g < dbc_pkg::NUM_BANKS; g++) begin : g_bank
      dbc_bank u_bank (
         .clock(clock),
         .rstn(rstn),
         .clk_en(clk_en),
         .hit(bhit[g] && cmd_ok),
         .cmd(cmd),
         .auto_pre(cmd_in.addr[dbc_pkg::AP_BIT]),
         .pre_all(pre_all),
         .state(bstate[g]),
         .legal(blegal[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // self refresh exit arrives without a clock edge, caught on cke rising
   always_ff @(posedge cke or negedge rstn) begin
      if (!rstn) begin
         sr_exit_seen_q <= 1'b0;
      end else begin
         sr_exit_seen_q <= ~sr_exit_seen_q;
      end
   end

   logic sr_tog_q;

   ////////////////////////////////////////////////////////////////////////////
   // device-wide state
   always_comb begin
      dev_d = dev_q;
      dcnt_d = (dcnt_q != dbc_pkg::CNT_ZERO) ? dcnt_q - dbc_pkg::CNT_ONE : dcnt_q;
      sr_d = sr_q;
      case (dev_q)
         dbc_pkg::DBC_DEV_NORMAL: begin
            if (valid && cmd_ok && cmd == dbc_pkg::DBC_CMD_REF) begin
               dev_d = dbc_pkg::DBC_DEV_REFRESH;
               dcnt_d = to_cnt(dbc_pkg::T_RFC_CK - 1);
            end else if (valid && cmd_ok && cmd == dbc_pkg::DBC_CMD_LMR) begin
               dev_d = dbc_pkg::DBC_DEV_MODE_REG;
               dcnt_d = to_cnt(dbc_pkg::T_MRD_CK - 1);
            end else if (cke_prev_q && !cke && cmd == dbc_pkg::DBC_CMD_SRE && all_idle) begin
               dev_d = dbc_pkg::DBC_DEV_SELF_REF;
               sr_d = 1'b1;
            end
         end
         dbc_pkg::DBC_DEV_REFRESH, dbc_pkg::DBC_DEV_MODE_REG: begin
            if (dcnt_q == dbc_pkg::CNT_ZERO) begin
               dev_d = dbc_pkg::DBC_DEV_NORMAL;
            end
         end
         dbc_pkg::DBC_DEV_SELF_REF: begin
            if (sr_tog_q != sr_exit_seen_q) begin
               dev_d = dbc_pkg::DBC_DEV_SR_EXIT;
               dcnt_d = to_cnt(dbc_pkg::T_XSNR_CK - 1);
               sr_d = 1'b0;
            end
         end
         dbc_pkg::DBC_DEV_SR_EXIT: begin
            if (dcnt_q == dbc_pkg::CNT_ZERO) begin
               dev_d = dbc_pkg::DBC_DEV_NORMAL;
            end
         end
         default: dev_d = dbc_pkg::DBC_DEV_NORMAL;
      endcase
   end

   // status outputs registered
   always_comb begin
      stat_d.bank_idle = bidle;
      for (int i = 0; i < dbc_pkg::NUM_BANKS; i++) begin
         stat_d.bank_open[i] = (bstate[i] == dbc_pkg::DBC_BK_ACTIVE) ||
                               (bstate[i] == dbc_pkg::DBC_BK_READ) ||
                               (bstate[i] == dbc_pkg::DBC_BK_WRITE);
         stat_d.bank_busy[i] = !bidle[i] && !stat_d.bank_open[i];
      end
      stat_d.accepted = valid && cmd_ok;
      // executable command refused, including any during busy states
      stat_d.illegal = !cmd_in.cs_n && cke && cmd != dbc_pkg::DBC_CMD_NONE &&
                       cmd != dbc_pkg::DBC_CMD_SRE && !(valid && cmd_ok);
      stat_d.mode_load = valid && cmd_ok && (cmd == dbc_pkg::DBC_CMD_LMR);
      stat_d.mode_sel = cmd_in.ba;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         dev_q <= dbc_pkg::DBC_DEV_NORMAL;
         dcnt_q <= dbc_pkg::CNT_ZERO;
         cke_prev_q <= 1'b0;
         sr_q <= 1'b0;
         sr_tog_q <= 1'b0;
         stat_q <= '0;
      end else if (clk_en) begin
         dev_q <= dev_d;
         dcnt_q <= dcnt_d;
         cke_prev_q <= cke;
         sr_q <= sr_d;
         // track every cke rise outside self refresh, so power-down exits
         // never look like a pending self refresh exit later on
         sr_tog_q <= (dev_q == dbc_pkg::DBC_DEV_SELF_REF) ? sr_tog_q : sr_exit_seen_q;
         stat_q <= stat_d;
      end
   end

   assign status = stat_q;
   assign dev_state = dev_q;
   assign self_refresh = sr_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_refresh_len;
      @(posedge clock) disable iff (!rstn)
      (clk_en && dev_q == dbc_pkg::DBC_DEV_NORMAL && dev_d == dbc_pkg::DBC_DEV_REFRESH)
      |=> (dev_q == dbc_pkg::DBC_DEV_REFRESH) [*8];
   endproperty
   a_refresh_len: assert property (p_refresh_len) else $error("refresh ended early");

   property p_ref_needs_idle;
      @(posedge clock) disable iff (!rstn)
      (valid && cmd == dbc_pkg::DBC_CMD_REF && cmd_ok) |-> all_idle;
   endproperty
   a_ref_needs_idle: assert property (p_ref_needs_idle) else $error("refresh not idle");

   property p_busy_blocks;
      @(posedge clock) disable iff (!rstn)
      (clk_en && dev_q != dbc_pkg::DBC_DEV_NORMAL) |=> !stat_q.accepted;
   endproperty
   a_busy_blocks: assert property (p_busy_blocks) else $error("command during busy");

   property p_nop_nothing;
      @(posedge clock) disable iff (!rstn)
      (clk_en && cmd == dbc_pkg::DBC_CMD_NONE) |=> !stat_q.accepted;
   endproperty
   a_nop_nothing: assert property (p_nop_nothing) else $error("nop accepted");

   property p_cke_gate;
      @(posedge clock) disable iff (!rstn)
      (clk_en && !cke_prev_q) |=> !stat_q.accepted;
   endproperty
   a_cke_gate: assert property (p_cke_gate) else $error("accepted with cke low");

   property p_mrd;
      @(posedge clock) disable iff (!rstn)
      (clk_en && dev_q == dbc_pkg::DBC_DEV_NORMAL && dev_d == dbc_pkg::DBC_DEV_MODE_REG)
      |=> (dev_q == dbc_pkg::DBC_DEV_MODE_REG) [*2];
   endproperty
   a_mrd: assert property (p_mrd) else $error("mode access too short");

   property p_act_rcd;
      @(posedge clock) disable iff (!rstn)
      (clk_en && $changed(bstate[0]) && bstate[0] == dbc_pkg::DBC_BK_ACTIVATING && clk_en)
      |-> ##1 (bstate[0] != dbc_pkg::DBC_BK_ACTIVE);
   endproperty
   a_act_rcd: assert property (p_act_rcd) else $error("trcd not honoured");

   property p_start_idle;
      @(posedge clock) $rose(rstn) |-> all_idle;
   endproperty
   a_start_idle: assert property (p_start_idle) else $error("banks not idle at start");

   // self refresh exit keeps the device in the exit state for at least 8 cycles of the exit delay
   sequence s_sr_exit_start;
      clk_en && dev_q == dbc_pkg::DBC_DEV_SELF_REF && dev_d == dbc_pkg::DBC_DEV_SR_EXIT;
   endsequence

   property p_sr_exit_hold;
      @(posedge clock) disable iff (!rstn)
      s_sr_exit_start |=> (dev_q == dbc_pkg::DBC_DEV_SR_EXIT) [*8];
   endproperty
   a_sr_exit_hold: assert property (p_sr_exit_hold) else $error("sr exit too short");

   // a read to an idle bank is refused and flagged
   property p_col_idle_refused;
      @(posedge clock) disable iff (!rstn)
      (clk_en && valid && cmd == dbc_pkg::DBC_CMD_RD && bidle[cmd_in.ba])
      |=> (!stat_q.accepted && stat_q.illegal);
   endproperty
   a_col_idle_refused: assert property (p_col_idle_refused) else $error("read to idle bank");

   // precharge all closes every bank, then all come back idle after trp
   sequence s_pre_all_taken;
      clk_en && valid && cmd_ok && cmd == dbc_pkg::DBC_CMD_PRE && pre_all;
   endsequence

   sequence s_all_back_idle;
      !all_idle ##[1:8] all_idle;
   endsequence

   property p_pre_all_done;
      @(posedge clock) disable iff (!rstn)
      s_pre_all_taken |=> s_all_back_idle;
   endproperty
   a_pre_all_done: assert property (p_pre_all_done) else $error("precharge all stuck");
endmodule // dbc_ctrl

// *** logic/dbc_pkg.sv ***
package dbc_pkg;
   // bank and timing geometry
   localparam int NUM_BANKS = 8;
   localparam int BA_W = 3;
   localparam int ADDR_W = 14;
   localparam int AP_BIT = 10;
   localparam int CNT_W = 8;
   localparam int CLK_PERIOD_PS = 4000;
   // times in picoseconds except tmrd in cycles, least times rounded up to cycles
   localparam int T_RP_PS = 12500;
   localparam int T_RCD_PS = 12500;
   localparam int T_RFC_PS = 197500;
   localparam int T_MRD_CK = 2;
   localparam int T_XSNR_PS = 207500;
   localparam int BURST_LEN = 4;
   localparam int T_RP_CK = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_RCD_CK = (T_RCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_RFC_CK = (T_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_XSNR_CK = (T_XSNR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int BURST_CK = BURST_LEN / 2;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

   // decoded command, one-hot
   typedef enum logic [7:0] {
      DBC_CMD_NONE = 8'h01,
      DBC_CMD_ACT = 8'h02,
      DBC_CMD_RD = 8'h04,
      DBC_CMD_WR = 8'h08,
      DBC_CMD_PRE = 8'h10,
      DBC_CMD_REF = 8'h20,
      DBC_CMD_LMR = 8'h40,
      DBC_CMD_SRE = 8'h80
   } dbc_cmd_t;

   // per-bank state, one-hot
   typedef enum logic [7:0] {
      DBC_BK_IDLE = 8'h01,
      DBC_BK_ACTIVATING = 8'h02,
      DBC_BK_ACTIVE = 8'h04,
      DBC_BK_READ = 8'h08,
      DBC_BK_WRITE = 8'h10,
      DBC_BK_RD_AP = 8'h20,
      DBC_BK_WR_AP = 8'h40,
      DBC_BK_PRECHARGING = 8'h80
   } dbc_bank_state_t;

   // device-wide state, one-hot
   typedef enum logic [4:0] {
      DBC_DEV_NORMAL = 5'h01,
      DBC_DEV_REFRESH = 5'h02,
      DBC_DEV_MODE_REG = 5'h04,
      DBC_DEV_SELF_REF = 5'h08,
      DBC_DEV_SR_EXIT = 5'h10
   } dbc_dev_state_t;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [BA_W-1:0] ba;
      logic [ADDR_W-1:0] addr;
   } dbc_cmd_bus_t;

   typedef struct packed {
      logic [NUM_BANKS-1:0] bank_idle;
      logic [NUM_BANKS-1:0] bank_open;
      logic [NUM_BANKS-1:0] bank_busy;
      logic accepted;
      logic illegal;
      logic mode_load;
      logic [BA_W-1:0] mode_sel;
   } dbc_status_t;
endpackage

// *** verif/dbc_ctl_model.sv ***
// memory controller model: issues one command, then holds nop
module dbc_ctl_model (
   // clock
   input wire logic clock,
   // command pins toward the device
   output logic cke,
   output dbc_pkg::dbc_cmd_bus_t cmd_in
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cke = 1'b1;
      cmd_in = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 14'h0000};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // nop after every command keeps busy banks and device-wide states undisturbed
   task automatic drive(input logic ck, input logic [3:0] code, input logic [2:0] ba,
                        input logic a10);
      @(negedge clock);
      cke = ck;
      {cmd_in.cs_n, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n} = code;
      cmd_in.ba = ba;
      cmd_in.addr = {3'h0, a10, 10'h000};
      @(negedge clock);
      {cmd_in.cs_n, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n} = 4'h7;
      // don't-care fields keep moving so stale values are never trusted
      cmd_in.ba = ~ba;
      cmd_in.addr = ~cmd_in.addr;
   endtask
endmodule // dbc_ctl_model

// *** verif/dbc_ctrl_tb_top.sv ***
module dbc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] C_LMR = 4'h0;
   localparam logic [3:0] C_REF = 4'h1;
   localparam logic [3:0] C_PRE = 4'h2;
   localparam logic [3:0] C_ACT = 4'h3;
   localparam logic [3:0] C_WR = 4'h4;
   localparam logic [3:0] C_RD = 4'h5;
   localparam logic [3:0] C_NOP = 4'h7;
   localparam logic [3:0] C_DES = 4'hB;
   localparam int RCD = dbc_pkg::T_RCD_CK;
   localparam int RP = dbc_pkg::T_RP_CK;

   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic clk_en = 1'b1;
   logic cke;
   dbc_pkg::dbc_cmd_bus_t cmd_in;
   dbc_pkg::dbc_status_t status;
   dbc_pkg::dbc_dev_state_t dev_state;
   logic self_refresh;
   int err_total = 0;
   int n_checks = 0;
   logic acc_seen;
   logic ill_seen;
   logic [2:0] sel_seen;
   int n;

   always #2 clock = ~clock;

   dbc_ctl_model i_ctl (.clock(clock), .cke(cke), .cmd_in(cmd_in));

   dbc_ctrl i_dut (
      .clock(clock),
      .rstn(rstn),
      .clk_en(clk_en),
      .cke(cke),
      .cmd_in(cmd_in),
      .status(status),
      .dev_state(dev_state),
      .self_refresh(self_refresh)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // answer pulses land within two cycles of the command edge
   task automatic collect();
      acc_seen = 1'b0;
      ill_seen = 1'b0;
      repeat (2) begin
         acc_seen = acc_seen | status.accepted;
         ill_seen = ill_seen | status.illegal;
         if (status.mode_load === 1'b1) sel_seen = status.mode_sel;
         @(negedge clock);
      end
   endtask

   task automatic issue(input logic [3:0] c, input logic [2:0] ba, input logic a10,
                        input logic acc);
      i_ctl.drive(1'b1, c, ba, a10);
      collect();
      check(acc_seen, acc);
   endtask

   task automatic wait_bank(input int b, input logic open, input int lim);
      int k;
      k = 0;
      while ((open ? status.bank_open[b] : status.bank_idle[b]) !== 1'b1 && k < lim) begin
         @(negedge clock);
         k++;
      end
      check(k < lim, 1'b1);
   endtask

   task automatic wait_normal(input int lim, output int k);
      k = 0;
      while (dev_state !== dbc_pkg::DBC_DEV_NORMAL && k < lim) begin
         @(negedge clock);
         k++;
      end
      check(k < lim, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check(status.bank_idle, 8'hFF);
      check(status.bank_open, 8'h00);
      check(dev_state, dbc_pkg::DBC_DEV_NORMAL);
      $display("test reset done");
   endtask

   task automatic t_row_cycle();
      issue(C_RD, 3'h5, 1'b0, 1'b0);
      check(ill_seen, 1'b1);
      issue(C_ACT, 3'h3, 1'b0, 1'b1);
      check(status.bank_open[3], 1'b0);
      wait_bank(3, 1'b1, RCD + 3);
      check(status.bank_open[5], 1'b0);
      issue(C_RD, 3'h3, 1'b0, 1'b1);
      issue(C_WR, 3'h3, 1'b0, 1'b1);
      issue(C_RD, 3'h3, 1'b0, 1'b1);
      issue(C_ACT, 3'h6, 1'b0, 1'b1);
      issue(C_PRE, 3'h3, 1'b0, 1'b1);
      check(status.bank_idle[3], 1'b0);
      wait_bank(3, 1'b0, RP + 3);
      wait_bank(6, 1'b1, RCD + 3);
      issue(C_PRE, 3'h6, 1'b0, 1'b1);
      wait_bank(6, 1'b0, RP + 3);
      $display("test row cycle done");
   endtask

   task automatic t_auto_pre();
      issue(C_ACT, 3'h1, 1'b0, 1'b1);
      wait_bank(1, 1'b1, RCD + 3);
      issue(C_RD, 3'h1, 1'b1, 1'b1);
      issue(C_ACT, 3'h2, 1'b0, 1'b1);
      wait_bank(1, 1'b0, dbc_pkg::BURST_CK + RP + 4);
      check(status.bank_open[1], 1'b0);
      wait_bank(2, 1'b1, RCD + 3);
      issue(C_WR, 3'h2, 1'b1, 1'b1);
      wait_bank(2, 1'b0, dbc_pkg::BURST_CK + RP + 8);
      $display("test auto precharge done");
   endtask

   task automatic t_refresh_mode();
      issue(C_REF, 3'h0, 1'b0, 1'b1);
      check(dev_state, dbc_pkg::DBC_DEV_REFRESH);
      wait_normal(dbc_pkg::T_RFC_CK + 2, n);
      check(n >= dbc_pkg::T_RFC_CK - 4, 1'b1);
      check(status.bank_idle, 8'hFF);
      for (int b = 0; b < dbc_pkg::NUM_BANKS; b++) begin
         sel_seen = 3'h0;
         issue(C_LMR, b[2:0], 1'b0, 1'b1);
         check(sel_seen, b[2:0]);
         wait_normal(dbc_pkg::T_MRD_CK + 3, n);
      end
      check(status.bank_idle, 8'hFF);
      $display("test refresh and mode done");
   endtask

   task automatic t_nop_pre_all();
      issue(C_ACT, 3'h4, 1'b0, 1'b1);
      wait_bank(4, 1'b1, RCD + 3);
      issue(C_DES, 3'h0, 1'b0, 1'b0);
      issue(C_NOP, 3'h0, 1'b0, 1'b0);
      check(status.bank_idle[0], 1'b1);
      check(status.bank_open[4], 1'b1);
      issue(C_PRE, 3'h0, 1'b1, 1'b1);
      wait_bank(4, 1'b0, RP + 3);
      check(status.bank_idle, 8'hFF);
      $display("test nop and precharge all done");
   endtask

   task automatic t_clock_enable();
      // controller keeps power-down short, so refresh needs stay met
      i_ctl.drive(1'b0, C_DES, 3'h0, 1'b0);
      i_ctl.drive(1'b1, C_ACT, 3'h0, 1'b0);
      collect();
      check(acc_seen, 1'b0);
      repeat (2) @(negedge clock);
      issue(C_ACT, 3'h0, 1'b0, 1'b1);
      wait_bank(0, 1'b1, RCD + 3);
      issue(C_PRE, 3'h0, 1'b0, 1'b1);
      wait_bank(0, 1'b0, RP + 3);
      i_ctl.drive(1'b0, C_REF, 3'h0, 1'b0);
      repeat (3) @(negedge clock);
      check(self_refresh, 1'b1);
      i_ctl.drive(1'b1, C_NOP, 3'h0, 1'b0);
      check(dev_state === dbc_pkg::DBC_DEV_NORMAL, 1'b0);
      wait_normal(dbc_pkg::T_XSNR_CK + 4, n);
      check(n >= dbc_pkg::T_XSNR_CK - 4, 1'b1);
      check(self_refresh, 1'b0);
      issue(C_ACT, 3'h7, 1'b0, 1'b1);
      $display("test clock enable done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(negedge clock);
      rstn = 1'b1;
      repeat (3) @(negedge clock);
      t_reset();
      t_row_cycle();
      t_auto_pre();
      t_refresh_mode();
      t_nop_pre_all();
      t_clock_enable();
      close_out();
   end

   initial begin
      #40000;
      err_total++;
      close_out();
   end
endmodule // dbc_ctrl_tb_top
